// ---- design/ocrb_config_bank.sv ----
// Operation
// - IBI clears on ack when bit set, else when served.
// - Idle time select: 50us, 2us, 1ms, 25ms.
// - Pin-one pull-down if enabled and unrouted or addressed.
// - Read-only signed rate deviation byte.
// - Stab registers writable from primary only when it owns them.
// - Stab data-ready overrides pin two.
// - Gate polarity: 0 active-low, 1 active-high.
// - Under primary control, aux output reads need enable.
// - Trigger,latched 10 is trigger mode, 11 latched.
// - Data gating applies to gyro only.
// - Aux wire mode: 0 four-wire, 1 three-wire.
// - Accel chain needs accel and gyro enables.
// - Gyro enable runs chain and owns first low-pass.
// - Gyro range 250 to 2000 dps; minimum bit forces 125.
// - High-pass only when enabled; cutoff from field.
// - Low-pass type code selects one of four cutoffs.
// - Accel code 01 gives 16 g, or 2 g with source bit.
// - Three-bit accel bandwidth field.
// - Self-test with clamp on forces 8000h.
// - Aux side reads accel range chosen by primary.
module ocrb_config_bank
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // Primary register port
  input  wire logic [7:0]  PRI_ADDR,
  input  wire logic        PRI_WE,
  input  wire logic [7:0]  PRI_WDATA,
  input  wire logic        PRI_RE,
  output logic [7:0]       PRI_RDATA,
  // Auxiliary register port
  input  wire logic [7:0]  AUX_ADDR,
  input  wire logic        AUX_WE,
  input  wire logic [7:0]  AUX_WDATA,
  input  wire logic        AUX_RE,
  output logic [7:0]       AUX_RDATA,
  output logic             AUX_OUT_READ_OK,
  output logic             AUX_THREE_WIRE,
  // Device state
  input  wire logic        PRIMARY_OWNS_STAB,
  input  wire logic [7:0]  RATE_DEVIATION,
  input  wire logic        ACCEL_RANGE_SOURCE,
  input  wire logic        SELF_TEST,
  // In-band interrupt
  input  wire logic        I3C_DYN_ADDR,
  input  wire logic        BUS_IDLE,
  input  wire logic        IBI_EVENT,
  input  wire logic        IBI_ACK,
  input  wire logic        IBI_SERVED,
  output logic             IBI_REQUEST,
  // Interrupt pins
  input  wire logic        IRQ1_ROUTED,
  input  wire logic        IRQ2_OTHER,
  input  wire logic        STAB_DRDY,
  output logic             IRQ_PIN_TWO,
  output logic             IRQ1_PULLDOWN_ON,
  // Data gate
  input  wire logic        DATA_GATE_PIN,
  output logic             GYRO_GATE_ACTIVE,
  output logic             GATE_LATCHED,
  // Chain settings
  output logic             GYRO_CHAIN_ON,
  output logic             ACCEL_CHAIN_ON,
  output logic             PRI_GYRO_OUT_VIS,
  output logic             PRI_ACCEL_OUT_VIS,
  output logic             FIRST_LOWPASS_GYRO,
  output logic [10:0]      GYRO_RANGE_DPS,
  output logic             HPF_ON,
  output logic [1:0]       HPF_CUTOFF,
  output logic [1:0]       LPF_TYPE,
  output logic [4:0]       ACCEL_RANGE_G,
  output logic [2:0]       ACCEL_BW,
  // Stabilisation sample path
  input  wire logic [15:0] STAB_SAMPLE_IN,
  output logic [15:0]      STAB_SAMPLE_OUT
);

  ocrb_store_if sif ();

  logic [7:0]  ibi_q;
  logic [7:0]  ibi_d;
  logic [7:0]  pri_loc_q;
  logic [7:0]  pri_loc_d;
  logic        pri_use_store_q;
  logic        pri_use_store_d;
  logic        aux_use_store_q;
  logic        aux_use_store_d;
  logic [15:0] sample_q;
  logic [15:0] sample_d;
  logic [7:0]  r_int;
  logic [7:0]  r_ctrl1;
  logic [7:0]  r_gyro;
  logic [7:0]  r_accel;
  logic        gate_level;
  logic        bus_avail;
  logic        ibi_pend;

  ocrb_stab_store u_store
  (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .sp  (sif.store)
  );

  ocrb_ibi_timer u_ibi
  (
    .clk           (REF_CLK),
    .rst           (SYS_RST),
    .idle_sel      (ibi_q[ocrb_pkg::IBI_SEL_LSB +: 2]),
    .clear_on_ack  (ibi_q[ocrb_pkg::IBI_CLR_ACK_BIT]),
    .bus_idle      (BUS_IDLE),
    .ibi_event     (IBI_EVENT),
    .ibi_ack       (IBI_ACK),
    .ibi_served    (IBI_SERVED),
    .bus_available (bus_avail),
    .ibi_pending   (ibi_pend)
  );

  assign r_int   = sif.cfg[ocrb_pkg::IDX_INT];
  assign r_ctrl1 = sif.cfg[ocrb_pkg::IDX_CTRL1];
  assign r_gyro  = sif.cfg[ocrb_pkg::IDX_GYRO];
  assign r_accel = sif.cfg[ocrb_pkg::IDX_ACCEL];

  always_comb
  begin
    sif.pri_we    = PRI_WE && PRIMARY_OWNS_STAB &&
                    ocrb_pkg::stab_hit(PRI_ADDR);
    sif.pri_idx   = ocrb_pkg::stab_idx(PRI_ADDR);
    sif.pri_wdata = PRI_WDATA;
    sif.aux_we    = AUX_WE && !PRIMARY_OWNS_STAB &&
                    ocrb_pkg::stab_hit(AUX_ADDR);
    sif.aux_idx   = ocrb_pkg::stab_idx(AUX_ADDR);
    sif.aux_wdata = AUX_WDATA;
    sif.pri_ridx  = ocrb_pkg::stab_idx(PRI_ADDR);
    sif.aux_ridx  = ocrb_pkg::stab_idx(AUX_ADDR);
  end

  always_comb
  begin
    ibi_d = ibi_q;
    if (PRI_WE && PRI_ADDR == ocrb_pkg::ADDR_IBI_IDLE)
    begin
      ibi_d = PRI_WDATA & ocrb_pkg::MASK_IBI_IDLE;
    end
  end

  // Local reads are registered alongside the store so both answer together.
  always_comb
  begin
    pri_loc_d       = pri_loc_q;
    pri_use_store_d = pri_use_store_q;
    aux_use_store_d = aux_use_store_q;
    if (PRI_RE)
    begin
      pri_use_store_d = ocrb_pkg::stab_hit(PRI_ADDR);
      unique case (PRI_ADDR)
        ocrb_pkg::ADDR_IBI_IDLE:  pri_loc_d = ibi_q;
        ocrb_pkg::ADDR_RATE_TRIM: pri_loc_d = RATE_DEVIATION;
        default:                  pri_loc_d = 8'h00;
      endcase
    end
    if (AUX_RE)
    begin
      aux_use_store_d = ocrb_pkg::stab_hit(AUX_ADDR);
    end
  end

  // Clamp sits on the chain output so every axis sees it equally.
  always_comb
  begin
    sample_d = STAB_SAMPLE_IN;
    if (SELF_TEST && !r_accel[ocrb_pkg::CLAMP_OFF_BIT])
    begin
      sample_d = ocrb_pkg::CLAMP_VALUE;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ibi_q           <= ocrb_pkg::RESET_VALUE;
      pri_loc_q       <= ocrb_pkg::RESET_VALUE;
      pri_use_store_q <= 1'b0;
      aux_use_store_q <= 1'b0;
      sample_q        <= 16'h0000;
    end
    else
    begin
      ibi_q           <= ibi_d;
      pri_loc_q       <= pri_loc_d;
      pri_use_store_q <= pri_use_store_d;
      aux_use_store_q <= aux_use_store_d;
      sample_q        <= sample_d;
    end
  end

  assign PRI_RDATA = pri_use_store_q ? sif.pri_rdata : pri_loc_q;
  assign AUX_RDATA = aux_use_store_q ? sif.aux_rdata : 8'h00;
  assign STAB_SAMPLE_OUT = sample_q;

  assign IBI_REQUEST = ibi_pend && bus_avail;

  assign IRQ1_PULLDOWN_ON = !ibi_q[ocrb_pkg::IRQ1_PD_DIS_BIT] &&
                            (!IRQ1_ROUTED || I3C_DYN_ADDR);

  assign IRQ_PIN_TWO = r_int[ocrb_pkg::DRDY_IRQ2_BIT] ?
                       STAB_DRDY : IRQ2_OTHER;

  assign gate_level = r_int[ocrb_pkg::GATE_POL_BIT] ?
                      DATA_GATE_PIN : !DATA_GATE_PIN;

  assign GATE_LATCHED     = r_ctrl1[ocrb_pkg::TRIGGER_BIT] &&
                            r_int[ocrb_pkg::LATCHED_BIT];
  assign GYRO_GATE_ACTIVE = r_ctrl1[ocrb_pkg::TRIGGER_BIT] &&
                            gate_level;

  // Outside primary ownership the aux port always reads its outputs.
  assign AUX_OUT_READ_OK = !PRIMARY_OWNS_STAB ||
                           r_int[ocrb_pkg::AUX_READ_BIT];
  assign AUX_THREE_WIRE  = r_ctrl1[ocrb_pkg::WIRE_MODE_BIT];

  assign GYRO_CHAIN_ON      = r_ctrl1[ocrb_pkg::GYRO_EN_BIT];
  assign ACCEL_CHAIN_ON     = r_ctrl1[ocrb_pkg::GYRO_EN_BIT] &&
                              r_ctrl1[ocrb_pkg::ACCEL_EN_BIT];
  assign PRI_GYRO_OUT_VIS   = PRIMARY_OWNS_STAB && GYRO_CHAIN_ON;
  assign PRI_ACCEL_OUT_VIS  = PRIMARY_OWNS_STAB && ACCEL_CHAIN_ON;
  assign FIRST_LOWPASS_GYRO = GYRO_CHAIN_ON;

  always_comb
  begin
    unique case (r_ctrl1[ocrb_pkg::GYRO_RANGE_LSB +: 2])
      2'b00: GYRO_RANGE_DPS = 11'h0fa;
      2'b01: GYRO_RANGE_DPS = 11'h1f4;
      2'b10: GYRO_RANGE_DPS = 11'h3e8;
      2'b11: GYRO_RANGE_DPS = 11'h7d0;
    endcase
    if (r_ctrl1[ocrb_pkg::GYRO_MIN_BIT])
    begin
      GYRO_RANGE_DPS = 11'h07d;
    end
  end

  assign HPF_ON     = r_gyro[ocrb_pkg::HPF_EN_BIT];
  assign HPF_CUTOFF = r_gyro[ocrb_pkg::HPF_CUT_LSB +: 2];
  assign LPF_TYPE   = r_gyro[ocrb_pkg::LPF_TYPE_LSB +: 2];

  always_comb
  begin
    unique case (r_accel[ocrb_pkg::ACCEL_RANGE_LSB +: 2])
      2'b00: ACCEL_RANGE_G = 5'h02;
      2'b01: ACCEL_RANGE_G = ACCEL_RANGE_SOURCE ? 5'h02 : 5'h10;
      2'b10: ACCEL_RANGE_G = 5'h04;
      2'b11: ACCEL_RANGE_G = 5'h08;
    endcase
  end

  assign ACCEL_BW = r_accel[ocrb_pkg::ACCEL_BW_LSB +: 3];

endmodule : ocrb_config_bank

// ---- design/ocrb_ibi_timer.sv ----
module ocrb_ibi_timer
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration
  input  wire logic [1:0] idle_sel,
  input  wire logic       clear_on_ack,
  // Bus events
  input  wire logic       bus_idle,
  input  wire logic       ibi_event,
  input  wire logic       ibi_ack,
  input  wire logic       ibi_served,
  // Status
  output logic            bus_available,
  output logic            ibi_pending
);

  ocrb_pkg::ocrb_idle_state_t state_q;
  ocrb_pkg::ocrb_idle_state_t state_d;
  logic [7:0]  tick_q;
  logic [7:0]  tick_d;
  logic [14:0] us_q;
  logic [14:0] us_d;
  logic        pend_q;
  logic        pend_d;
  logic        tick;
  logic [14:0] limit;

  always_comb
  begin
    unique case (idle_sel)
      2'b00: limit = ocrb_pkg::IDLE_US_SEL0;
      2'b01: limit = ocrb_pkg::IDLE_US_SEL1;
      2'b10: limit = ocrb_pkg::IDLE_US_SEL2;
      2'b11: limit = ocrb_pkg::IDLE_US_SEL3;
    endcase
  end

  // The divider restarts with each idle phase so the first tick is whole.
  assign tick = (tick_q == 8'(ocrb_pkg::TICK_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    tick_d  = 8'h00;
    us_d    = 15'h0000;
    unique case (state_q)
      ocrb_pkg::IBI_IDLE:
      begin
        if (bus_idle)
        begin
          state_d = ocrb_pkg::IBI_COUNT;
        end
      end
      ocrb_pkg::IBI_COUNT:
      begin
        tick_d = tick ? 8'h00 : tick_q + 8'h01;
        us_d   = tick ? us_q + 15'h0001 : us_q;
        if (!bus_idle)
        begin
          state_d = ocrb_pkg::IBI_IDLE;
        end
        else if (tick && us_q + 15'h0001 >= limit)
        begin
          state_d = ocrb_pkg::IBI_AVAIL;
        end
      end
      ocrb_pkg::IBI_AVAIL:
      begin
        if (!bus_idle)
        begin
          state_d = ocrb_pkg::IBI_IDLE;
        end
      end
      default:
      begin
        state_d = ocrb_pkg::IBI_IDLE;
      end
    endcase
  end

  // A new event in the clearing cycle keeps the interrupt pending.
  always_comb
  begin
    pend_d = pend_q;
    if (clear_on_ack ? ibi_ack : ibi_served)
    begin
      pend_d = 1'b0;
    end
    if (ibi_event)
    begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ocrb_pkg::IBI_IDLE;
      tick_q  <= 8'h00;
      us_q    <= 15'h0000;
      pend_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tick_q  <= tick_d;
      us_q    <= us_d;
      pend_q  <= pend_d;
    end
  end

  assign bus_available = (state_q == ocrb_pkg::IBI_AVAIL);
  assign ibi_pending   = pend_q;

endmodule : ocrb_ibi_timer

// ---- design/ocrb_stab_store.sv ----
module ocrb_stab_store
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst,
  // Owner side
  ocrb_store_if.store sp
);

  logic [7:0] mem_q [4];
  logic [7:0] mem_d [4];
  logic [7:0] pri_rdata_q;
  logic [7:0] pri_rdata_d;
  logic [7:0] aux_rdata_q;
  logic [7:0] aux_rdata_d;

  // One copy serves both ports, so a change of owner never moves data.
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_slot
      always_comb
      begin
        mem_d[g] = mem_q[g];
        if (sp.pri_we && sp.pri_idx == 2'(g))
        begin
          mem_d[g] = sp.pri_wdata & ocrb_pkg::stab_mask(2'(g));
        end
        else if (sp.aux_we && sp.aux_idx == 2'(g))
        begin
          mem_d[g] = sp.aux_wdata & ocrb_pkg::stab_mask(2'(g));
        end
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          mem_q[g] <= ocrb_pkg::RESET_VALUE;
        end
        else
        begin
          mem_q[g] <= mem_d[g];
        end
      end

      assign sp.cfg[g] = mem_q[g];
    end
  endgenerate

  always_comb
  begin
    pri_rdata_d = mem_q[sp.pri_ridx];
    aux_rdata_d = mem_q[sp.aux_ridx];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pri_rdata_q <= ocrb_pkg::RESET_VALUE;
      aux_rdata_q <= ocrb_pkg::RESET_VALUE;
    end
    else
    begin
      pri_rdata_q <= pri_rdata_d;
      aux_rdata_q <= aux_rdata_d;
    end
  end

  assign sp.pri_rdata = pri_rdata_q;
  assign sp.aux_rdata = aux_rdata_q;

endmodule : ocrb_stab_store

// ---- include/ocrb_pkg.sv ----
package ocrb_pkg;

  localparam logic [7:0] ADDR_IBI_IDLE   = 8'h62;
  localparam logic [7:0] ADDR_RATE_TRIM  = 8'h63;
  localparam logic [7:0] ADDR_STAB_INT   = 8'h6f;
  localparam logic [7:0] ADDR_STAB_CTRL1 = 8'h70;
  localparam logic [7:0] ADDR_STAB_GYRO  = 8'h71;
  localparam logic [7:0] ADDR_STAB_ACCEL = 8'h72;
  localparam logic [7:0] ADDR_OUT_FIRST  = 8'h22;
  localparam logic [7:0] ADDR_OUT_LAST   = 8'h2d;

  localparam logic [7:0] MASK_IBI_IDLE   = 8'h59;
  localparam logic [7:0] MASK_STAB_INT   = 8'he8;
  localparam logic [7:0] MASK_STAB_CTRL1 = 8'h7f;
  localparam logic [7:0] MASK_STAB_GYRO  = 8'h37;
  localparam logic [7:0] MASK_STAB_ACCEL = 8'hf9;
  localparam logic [7:0] RESET_VALUE     = 8'h00;

  localparam int IBI_CLR_ACK_BIT = 6;
  localparam int IBI_SEL_LSB     = 3;
  localparam int IRQ1_PD_DIS_BIT = 0;

  localparam int DRDY_IRQ2_BIT   = 7;
  localparam int LATCHED_BIT     = 6;
  localparam int GATE_POL_BIT    = 5;
  localparam int AUX_READ_BIT    = 3;

  localparam int TRIGGER_BIT     = 6;
  localparam int WIRE_MODE_BIT   = 5;
  localparam int ACCEL_EN_BIT    = 4;
  localparam int GYRO_RANGE_LSB  = 2;
  localparam int GYRO_MIN_BIT    = 1;
  localparam int GYRO_EN_BIT     = 0;

  localparam int HPF_CUT_LSB     = 4;
  localparam int LPF_TYPE_LSB    = 1;
  localparam int HPF_EN_BIT      = 0;

  localparam int ACCEL_RANGE_LSB = 6;
  localparam int ACCEL_BW_LSB    = 3;
  localparam int CLAMP_OFF_BIT   = 0;

  localparam logic [1:0] IDX_INT   = 2'h0;
  localparam logic [1:0] IDX_CTRL1 = 2'h1;
  localparam logic [1:0] IDX_GYRO  = 2'h2;
  localparam logic [1:0] IDX_ACCEL = 2'h3;

  localparam logic [15:0] CLAMP_VALUE = 16'h8000;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_PS       = 1000000;
  localparam int TICK_CYCLES   = TICK_PS / CLK_PERIOD_PS;
  localparam logic [14:0] IDLE_US_SEL0 = 15'h0032;
  localparam logic [14:0] IDLE_US_SEL1 = 15'h0002;
  localparam logic [14:0] IDLE_US_SEL2 = 15'h03e8;
  localparam logic [14:0] IDLE_US_SEL3 = 15'h61a8;

  typedef enum logic [1:0]
  {
    IBI_IDLE  = 2'b00,
    IBI_COUNT = 2'b01,
    IBI_AVAIL = 2'b11
  } ocrb_idle_state_t;

  function automatic logic stab_hit(input logic [7:0] addr);
    stab_hit = (addr == ADDR_STAB_INT) || (addr == ADDR_STAB_CTRL1) ||
      (addr == ADDR_STAB_GYRO) || (addr == ADDR_STAB_ACCEL);
  endfunction : stab_hit

  function automatic logic [1:0] stab_idx(input logic [7:0] addr);
    stab_idx = 2'(addr - ADDR_STAB_INT);
  endfunction : stab_idx

  function automatic logic [7:0] stab_mask(input logic [1:0] idx);
    unique case (idx)
      IDX_INT:   stab_mask = MASK_STAB_INT;
      IDX_CTRL1: stab_mask = MASK_STAB_CTRL1;
      IDX_GYRO:  stab_mask = MASK_STAB_GYRO;
      IDX_ACCEL: stab_mask = MASK_STAB_ACCEL;
    endcase
  endfunction : stab_mask

endpackage : ocrb_pkg

// ---- include/ocrb_store_if.sv ----
interface ocrb_store_if;
  logic       pri_we;
  logic [1:0] pri_idx;
  logic [7:0] pri_wdata;
  logic       aux_we;
  logic [1:0] aux_idx;
  logic [7:0] aux_wdata;
  logic [1:0] pri_ridx;
  logic [1:0] aux_ridx;
  logic [7:0] pri_rdata;
  logic [7:0] aux_rdata;
  logic [7:0] cfg [4];

  modport owner
  (
    output pri_we, pri_idx, pri_wdata, aux_we, aux_idx, aux_wdata,
    output pri_ridx, aux_ridx,
    input  pri_rdata, aux_rdata, cfg
  );

  modport store
  (
    input  pri_we, pri_idx, pri_wdata, aux_we, aux_idx, aux_wdata,
    input  pri_ridx, aux_ridx,
    output pri_rdata, aux_rdata, cfg
  );
endinterface : ocrb_store_if

// ---- verification/ocrb_aux_host.sv ----
module ocrb_aux_host
(
  // Clock
  input  wire logic       clk,
  // Auxiliary register port
  output logic [7:0]      aux_addr,
  output logic            aux_we,
  output logic [7:0]      aux_wdata,
  output logic            aux_re,
  input  wire logic [7:0] aux_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    {aux_addr, aux_we, aux_wdata, aux_re} = '0;
  end

  // Callers pass zero in reserved positions.
  task automatic aw(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    aux_addr = a;
    aux_wdata = d;
    aux_we = 1'b1;
    @(negedge clk);
    aux_we = 1'b0;
    aux_addr = ~a;
    aux_wdata = ~d;
  endtask : aw

  // Released lines show the inverse so stale values cannot pass.
  task automatic ar(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    aux_addr = a;
    aux_re = 1'b1;
    @(negedge clk);
    aux_re = 1'b0;
    d = aux_rdata;
    aux_addr = ~a;
  endtask : ar
endmodule : ocrb_aux_host

// ---- verification/ocrb_config_bank_chk.sv ----
module ocrb_config_bank_chk
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // Register ports
  input wire logic [7:0]  PRI_ADDR,
  input wire logic        PRI_WE,
  input wire logic [7:0]  PRI_WDATA,
  input wire logic        PRI_RE,
  input wire logic [7:0]  PRI_RDATA,
  input wire logic        AUX_WE,
  input wire logic        AUX_OUT_READ_OK,
  input wire logic        AUX_THREE_WIRE,
  input wire logic        PRIMARY_OWNS_STAB,
  input wire logic [7:0]  RATE_DEVIATION,
  // Events and pins
  input wire logic        SELF_TEST,
  input wire logic        BUS_IDLE,
  input wire logic        IBI_ACK,
  input wire logic        IBI_SERVED,
  input wire logic        IBI_REQUEST,
  input wire logic        I3C_DYN_ADDR,
  input wire logic        IRQ1_ROUTED,
  input wire logic        IRQ2_OTHER,
  input wire logic        STAB_DRDY,
  input wire logic        IRQ_PIN_TWO,
  input wire logic        IRQ1_PULLDOWN_ON,
  // Chain state
  input wire logic        GYRO_CHAIN_ON,
  input wire logic        ACCEL_CHAIN_ON,
  input wire logic [10:0] GYRO_RANGE_DPS,
  input wire logic [15:0] STAB_SAMPLE_IN,
  input wire logic [15:0] STAB_SAMPLE_OUT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // Saturating idle count; ten bits cover the shortest bus wait.
  logic [9:0] idle_n_q;
  logic [9:0] idle_n_d;

  always_comb
  begin
    idle_n_d = (&idle_n_q) ? idle_n_q : idle_n_q + 10'h001;
    if (!BUS_IDLE)
    begin
      idle_n_d = 10'h000;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    idle_n_q <= SYS_RST ? 10'h000 : idle_n_d;
  end

  sequence s_ctrl1_wr;
    PRI_WE && (PRI_ADDR == ocrb_pkg::ADDR_STAB_CTRL1) && !AUX_WE;
  endsequence

  property p_own_write;
    s_ctrl1_wr ##0 PRIMARY_OWNS_STAB |=> GYRO_CHAIN_ON == $past(PRI_WDATA[0]);
  endproperty
  a_own_write: assert property (p_own_write)
    else $error("Owned write not applied.");

  property p_refused;
    s_ctrl1_wr ##0 !PRIMARY_OWNS_STAB
      |=> $stable(GYRO_CHAIN_ON) && $stable(AUX_THREE_WIRE);
  endproperty
  a_refused: assert property (p_refused)
    else $error("Refused write changed state.");

  property p_rd_trim;
    PRI_RE && (PRI_ADDR == ocrb_pkg::ADDR_RATE_TRIM)
      |=> PRI_RDATA == $past(RATE_DEVIATION);
  endproperty
  a_rd_trim: assert property (p_rd_trim)
    else $error("Trim readout wrong.");

  property p_pin_two;
    (IRQ_PIN_TWO == STAB_DRDY) || (IRQ_PIN_TWO == IRQ2_OTHER);
  endproperty
  a_pin_two: assert property (p_pin_two)
    else $error("Pin two from no source.");

  property p_pulldown;
    IRQ1_PULLDOWN_ON |-> !IRQ1_ROUTED || I3C_DYN_ADDR;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("Pull-down on while routed.");

  property p_dps;
    GYRO_RANGE_DPS inside {11'h07d, 11'h0fa, 11'h1f4, 11'h3e8, 11'h7d0};
  endproperty
  a_dps: assert property (p_dps)
    else $error("Gyro range not legal.");

  property p_accel_chain;
    ACCEL_CHAIN_ON |-> GYRO_CHAIN_ON;
  endproperty
  a_accel_chain: assert property (p_accel_chain)
    else $error("Accel chain without gyro.");

  property p_aux_ok;
    !PRIMARY_OWNS_STAB |-> AUX_OUT_READ_OK;
  endproperty
  a_aux_ok: assert property (p_aux_ok)
    else $error("Aux output read blocked.");

  property p_sample;
    !SELF_TEST |=> STAB_SAMPLE_OUT == $past(STAB_SAMPLE_IN);
  endproperty
  a_sample: assert property (p_sample)
    else $error("Sample not passed.");

  property p_clamp;
    SELF_TEST |=> (STAB_SAMPLE_OUT == ocrb_pkg::CLAMP_VALUE) ||
      (STAB_SAMPLE_OUT == $past(STAB_SAMPLE_IN));
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("Self-test output wrong.");

  property p_ibi_idle;
    (!BUS_IDLE) [*2] |-> !IBI_REQUEST;
  endproperty
  a_ibi_idle: assert property (p_ibi_idle)
    else $error("Request on busy bus.");

  property p_ibi_min;
    $rose(IBI_REQUEST) |-> idle_n_q >= 10'h1f4;
  endproperty
  a_ibi_min: assert property (p_ibi_min)
    else $error("Request before idle time.");

  property p_ibi_hold;
    IBI_REQUEST && BUS_IDLE && !IBI_ACK && !IBI_SERVED |=> IBI_REQUEST;
  endproperty
  a_ibi_hold: assert property (p_ibi_hold)
    else $error("Request dropped without clear.");
endmodule : ocrb_config_bank_chk

bind ocrb_config_bank ocrb_config_bank_chk chk_i
(
  .REF_CLK, .SYS_RST, .PRI_ADDR, .PRI_WE, .PRI_WDATA, .PRI_RE, .PRI_RDATA,
  .AUX_WE, .AUX_OUT_READ_OK, .AUX_THREE_WIRE, .PRIMARY_OWNS_STAB,
  .RATE_DEVIATION, .SELF_TEST, .BUS_IDLE, .IBI_ACK, .IBI_SERVED,
  .IBI_REQUEST, .I3C_DYN_ADDR, .IRQ1_ROUTED, .IRQ2_OTHER, .STAB_DRDY,
  .IRQ_PIN_TWO, .IRQ1_PULLDOWN_ON, .GYRO_CHAIN_ON, .ACCEL_CHAIN_ON,
  .GYRO_RANGE_DPS, .STAB_SAMPLE_IN, .STAB_SAMPLE_OUT
);

// ---- verification/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed
  {
    logic [7:0]  a;
    logic [7:0]  d;
    logic [10:0] v;
  } ocrb_row_t;

  logic REF_CLK, SYS_RST, PRI_WE, PRI_RE, AUX_WE, AUX_RE, AUX_OUT_READ_OK;
  logic AUX_THREE_WIRE, PRIMARY_OWNS_STAB, ACCEL_RANGE_SOURCE, SELF_TEST;
  logic I3C_DYN_ADDR, BUS_IDLE, IBI_EVENT, IBI_ACK, IBI_SERVED, IBI_REQUEST;
  logic IRQ1_ROUTED, IRQ2_OTHER, STAB_DRDY, IRQ_PIN_TWO, IRQ1_PULLDOWN_ON;
  logic DATA_GATE_PIN, GYRO_GATE_ACTIVE, GATE_LATCHED, GYRO_CHAIN_ON;
  logic ACCEL_CHAIN_ON, PRI_GYRO_OUT_VIS, PRI_ACCEL_OUT_VIS, HPF_ON;
  logic FIRST_LOWPASS_GYRO;
  logic [7:0]  PRI_ADDR, PRI_WDATA, PRI_RDATA, AUX_ADDR, AUX_WDATA;
  logic [7:0]  AUX_RDATA, RATE_DEVIATION, rd;
  logic [10:0] GYRO_RANGE_DPS;
  logic [1:0]  HPF_CUTOFF, LPF_TYPE;
  logic [4:0]  ACCEL_RANGE_G;
  logic [2:0]  ACCEL_BW;
  logic [15:0] STAB_SAMPLE_IN, STAB_SAMPLE_OUT, obs;
  int          n_fail;
  int          tests_run;

  ocrb_row_t rows [17] = '{
    '{8'h70, 8'h00, 11'h0fa}, '{8'h70, 8'h04, 11'h1f4},
    '{8'h70, 8'h08, 11'h3e8}, '{8'h70, 8'h0c, 11'h7d0},
    '{8'h70, 8'h0e, 11'h07d}, '{8'h70, 8'h02, 11'h07d},
    '{8'h71, 8'h01, 11'h010}, '{8'h71, 8'h31, 11'h01c},
    '{8'h71, 8'h06, 11'h003}, '{8'h71, 8'h22, 11'h009},
    '{8'h71, 8'h11, 11'h014}, '{8'h72, 8'h00, 11'h010},
    '{8'h72, 8'h40, 11'h080}, '{8'h72, 8'h88, 11'h021},
    '{8'h72, 8'hd0, 11'h042}, '{8'h72, 8'h38, 11'h017},
    '{8'h72, 8'he0, 11'h044}};

  ocrb_config_bank dut
  (
    .REF_CLK, .SYS_RST, .PRI_ADDR, .PRI_WE, .PRI_WDATA, .PRI_RE, .PRI_RDATA,
    .AUX_ADDR, .AUX_WE, .AUX_WDATA, .AUX_RE, .AUX_RDATA, .AUX_OUT_READ_OK,
    .AUX_THREE_WIRE, .PRIMARY_OWNS_STAB, .RATE_DEVIATION, .ACCEL_RANGE_SOURCE,
    .SELF_TEST, .I3C_DYN_ADDR, .BUS_IDLE, .IBI_EVENT, .IBI_ACK, .IBI_SERVED,
    .IBI_REQUEST, .IRQ1_ROUTED, .IRQ2_OTHER, .STAB_DRDY, .IRQ_PIN_TWO,
    .IRQ1_PULLDOWN_ON, .DATA_GATE_PIN, .GYRO_GATE_ACTIVE, .GATE_LATCHED,
    .GYRO_CHAIN_ON, .ACCEL_CHAIN_ON, .PRI_GYRO_OUT_VIS, .PRI_ACCEL_OUT_VIS,
    .FIRST_LOWPASS_GYRO, .GYRO_RANGE_DPS, .HPF_ON, .HPF_CUTOFF, .LPF_TYPE,
    .ACCEL_RANGE_G, .ACCEL_BW, .STAB_SAMPLE_IN, .STAB_SAMPLE_OUT
  );

  ocrb_aux_host aux
  (
    .clk       (REF_CLK),
    .aux_addr  (AUX_ADDR),
    .aux_we    (AUX_WE),
    .aux_wdata (AUX_WDATA),
    .aux_re    (AUX_RE),
    .aux_rdata (AUX_RDATA)
  );

  always #2 REF_CLK = ~REF_CLK;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc

  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    PRI_ADDR = a;
    PRI_WDATA = d;
    PRI_WE = 1'b1;
    cyc(1);
    PRI_WE = 1'b0;
    PRI_ADDR = ~a;
    PRI_WDATA = ~d;
  endtask : pw

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    PRI_ADDR = a;
    PRI_RE = 1'b1;
    cyc(1);
    PRI_RE = 1'b0;
    chk(PRI_RDATA, exp);
  endtask : rdchk

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // The longest wait is the 2 us bus idle; the margin is wide.
  initial
  begin
    repeat (30000) @(posedge REF_CLK);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    {REF_CLK, PRI_WE, PRI_RE, PRIMARY_OWNS_STAB, ACCEL_RANGE_SOURCE} = '0;
    {SELF_TEST, I3C_DYN_ADDR, BUS_IDLE, IBI_EVENT, IBI_ACK, IBI_SERVED} = '0;
    {IRQ1_ROUTED, IRQ2_OTHER, STAB_DRDY, DATA_GATE_PIN} = '0;
    {PRI_ADDR, PRI_WDATA, RATE_DEVIATION, STAB_SAMPLE_IN} = '0;
    SYS_RST = 1'b1;
    cyc(8);
    SYS_RST = 1'b0;
    PRIMARY_OWNS_STAB = 1'b1;
    foreach (rows[i])
    begin
      pw(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].d);
      obs = (rows[i].a == ocrb_pkg::ADDR_STAB_CTRL1) ?
        {5'h00, GYRO_RANGE_DPS} : (rows[i].a == ocrb_pkg::ADDR_STAB_GYRO) ?
        {11'h000, HPF_ON, HPF_CUTOFF, LPF_TYPE} :
        {8'h00, ACCEL_RANGE_G, ACCEL_BW};
      chk(obs, {5'h00, rows[i].v});
      $display("row %0d done", i);
    end
    pw(8'h70, 8'h01);
    PRIMARY_OWNS_STAB = 1'b0;
    pw(8'h70, 8'h10);
    rdchk(8'h70, 8'h01);
    aux.aw(8'h70, 8'h20);
    rdchk(8'h70, 8'h20);
    chk(AUX_THREE_WIRE, 1'b1);
    aux.aw(8'h70, 8'h00);
    PRIMARY_OWNS_STAB = 1'b1;
    pw(8'h6f, 8'h08);
    chk(AUX_OUT_READ_OK, 1'b1);
    pw(8'h6f, 8'h00);
    chk(AUX_OUT_READ_OK, 1'b0);
    RATE_DEVIATION = 8'h9c;
    pw(8'h63, 8'h55);
    rdchk(8'h63, 8'h9c);
    $display("ownership and trim done");
    IRQ2_OTHER = 1'b1;
    #1 chk(IRQ_PIN_TWO, 1'b1);
    pw(8'h6f, 8'h80);
    chk(IRQ_PIN_TWO, 1'b0);
    {STAB_DRDY, IRQ2_OTHER} = 2'b10;
    #1 chk(IRQ_PIN_TWO, 1'b1);
    pw(8'h70, 8'h41);
    pw(8'h6f, 8'h00);
    #1 chk(GYRO_GATE_ACTIVE, 1'b1);
    DATA_GATE_PIN = 1'b1;
    #1 chk(GYRO_GATE_ACTIVE, 1'b0);
    pw(8'h6f, 8'h60);
    chk({GATE_LATCHED, GYRO_GATE_ACTIVE}, 2'b11);
    pw(8'h70, 8'h10);
    chk({GATE_LATCHED, GYRO_CHAIN_ON, ACCEL_CHAIN_ON}, 3'b000);
    pw(8'h70, 8'h11);
    chk({ACCEL_CHAIN_ON, FIRST_LOWPASS_GYRO, PRI_GYRO_OUT_VIS,
      PRI_ACCEL_OUT_VIS}, 4'hf);
    ACCEL_RANGE_SOURCE = 1'b1;
    pw(8'h72, 8'h40);
    chk(ACCEL_RANGE_G, 5'h02);
    aux.ar(8'h72, rd);
    chk(rd, 8'h40);
    {SELF_TEST, STAB_SAMPLE_IN} = {1'b1, 16'h1234};
    pw(8'h72, 8'h00);
    chk(STAB_SAMPLE_OUT, 16'h8000);
    pw(8'h72, 8'h01);
    cyc(1);
    chk(STAB_SAMPLE_OUT, 16'h1234);
    $display("routing and chains done");
    IRQ1_ROUTED = 1'b1;
    #1 chk(IRQ1_PULLDOWN_ON, 1'b0);
    I3C_DYN_ADDR = 1'b1;
    #1 chk(IRQ1_PULLDOWN_ON, 1'b1);
    pw(8'h62, 8'h01);
    chk(IRQ1_PULLDOWN_ON, 1'b0);
    pw(8'h62, 8'h08);
    {BUS_IDLE, IBI_EVENT} = 2'b11;
    cyc(1);
    IBI_EVENT = 1'b0;
    cyc(400);
    chk(IBI_REQUEST, 1'b0);
    cyc(110);
    chk(IBI_REQUEST, 1'b1);
    IBI_ACK = 1'b1;
    cyc(1);
    IBI_ACK = 1'b0;
    chk(IBI_REQUEST, 1'b1);
    IBI_SERVED = 1'b1;
    cyc(1);
    IBI_SERVED = 1'b0;
    chk(IBI_REQUEST, 1'b0);
    pw(8'h62, 8'h48);
    IBI_EVENT = 1'b1;
    cyc(1);
    {IBI_EVENT, IBI_ACK} = 2'b01;
    chk(IBI_REQUEST, 1'b1);
    cyc(1);
    {IBI_ACK, BUS_IDLE} = 2'b00;
    chk(IBI_REQUEST, 1'b0);
    cyc(2);
    $display("interrupt timing done");
    SYS_RST = 1'b1;
    cyc(8);
    SYS_RST = 1'b0;
    rdchk(8'h70, 8'h00);
    chk({GYRO_RANGE_DPS, ACCEL_RANGE_G}, {11'h0fa, 5'h02});
    $display("reset done");
    report_and_stop();
  end
endmodule : tb
